// *** sfe_asserts.sv ***
// Port checker for sfe_flash_seq, bound at the foot of this file.
// Assumes one mclk domain and ext_busy low while an erase runs.
`timescale 1ns/1ps
`default_nettype none
module sfe_asserts #(
  parameter [31:0] ERASE64K_CYC = 32'd20,
  parameter [31:0] WIPE_CYC = 32'd30
) (
  input wire mclk,
  input wire arst_n,
  input wire spi_cs_n,
  input wire [3:0] io_oe_n,
  input wire [3:0] protect_level_bits,
  input wire busy_flag,
  input wire write_unlock_latch,
  input wire deep_sleep,
  input wire four_line_cmd_mode,
  input wire erase_64k_go,
  input wire [2:0] erase_block,
  input wire array_wipe_go
);
  localparam int BE_MAX = ERASE64K_CYC + 4; // Slack for load and flag lag
  localparam int WP_MAX = WIPE_CYC + 4;
  wire go = erase_64k_go | array_wipe_go; // Any erase start
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Protected blocks per level
  function automatic logic hit(input [3:0] l, input [2:0] b);
    return l == 4'h0 ? 1'b0 : l == 4'h1 ? b == 3'd7 : l == 4'h2 ? b >= 3'd6 :
      l == 4'h3 ? b >= 3'd4 : 1'b1;
  endfunction
  AST_GO_LATCH: assert property (go |-> $past(write_unlock_latch))
    else $error("erase started without latch");
  AST_GO_CLR: assert property (go |-> !write_unlock_latch)
    else $error("latch still set at erase start");
  AST_BE_BUSY: assert property (erase_64k_go |=> busy_flag[*8] ##[1:BE_MAX] !busy_flag)
    else $error("block erase busy span wrong");
  AST_CE_BUSY: assert property (array_wipe_go |=> busy_flag[*8] ##[1:WP_MAX] !busy_flag)
    else $error("array erase busy span wrong");
  AST_BE_PROT: assert property (erase_64k_go
    |-> !hit($past(protect_level_bits), erase_block))
    else $error("protected block erased");
  AST_CE_PROT: assert property (array_wipe_go |-> $past(protect_level_bits) == 4'h0)
    else $error("array erased with protection");
  AST_GO_IDLE: assert property (go |-> !$past(busy_flag) && !$past(deep_sleep))
    else $error("erase started while busy or asleep");
  AST_GO_PULSE: assert property (go |=> !go)
    else $error("start pulse too long");
  AST_OE_DESEL: assert property (spi_cs_n[*6] |-> io_oe_n == 4'hf)
    else $error("output driven while deselected");
  AST_OE_MODE: assert property (io_oe_n != 4'hf
    |-> io_oe_n == (four_line_cmd_mode ? 4'h0 : 4'hd))
    else $error("output lanes wrong for mode");
  AST_SLEEP_IDLE: assert property ($rose(deep_sleep)
    |-> !busy_flag && $past(spi_cs_n, 100))
    else $error("sleep entered too early or while busy");
  AST_RST_STBY: assert property ($rose(arst_n) |-> !deep_sleep && !busy_flag)
    else $error("not in standby after reset");
  cover property (erase_64k_go);
  cover property (array_wipe_go);
  cover property ($rose(deep_sleep));
  cover property (io_oe_n == 4'h0);
endmodule
bind sfe_flash_seq sfe_asserts #(.ERASE64K_CYC(ERASE64K_CYC), .WIPE_CYC(WIPE_CYC)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .spi_cs_n(spi_cs_n), .io_oe_n(io_oe_n),
  .protect_level_bits(protect_level_bits), .busy_flag(busy_flag),
  .write_unlock_latch(write_unlock_latch), .deep_sleep(deep_sleep),
  .four_line_cmd_mode(four_line_cmd_mode), .erase_64k_go(erase_64k_go),
  .erase_block(erase_block), .array_wipe_go(array_wipe_go));
`default_nettype wire

// *** sfe_flash_seq.v ***
// Serial flash instruction sequencer: 64KB block erase, whole-array erase,
// deep sleep entry and wake, legacy ID reads, write unlock, four-line mode.
// Assumes the SPI clock is well below a sixth of mclk; the array applies
// erases on the go pulses and ext_busy reports program/status-write cycles.
`timescale 1ns/1ps
`default_nettype none
`include "sfe_regs.vh"

module sfe_flash_seq #(
  parameter [31:0] ERASE64K_CYC = `SFE_ERASE64K_CYC,
  parameter [31:0] WIPE_CYC = `SFE_WIPE_CYC,
  parameter [7:0] DEV_ID = 8'h5a, // Arbitrary value
  parameter [7:0] MFR_ID = 8'ha5  // Arbitrary value
) (
  input wire mclk,
  input wire arst_n,
  input wire ce,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire [3:0] io_in,
  output wire [3:0] io_out,
  output wire [3:0] io_oe_n,
  input wire [3:0] protect_level_bits,
  input wire ext_busy,
  output wire busy_flag,
  output wire write_unlock_latch,
  output wire deep_sleep,
  output wire four_line_cmd_mode,
  output wire erase_64k_go,
  output wire [2:0] erase_block,
  output wire array_wipe_go
);

  // Power states
  localparam [1:0] PW_STBY = 2'd0;
  localparam [1:0] PW_ENTER = 2'd1;
  localparam [1:0] PW_SLEEP = 2'd2;
  localparam [1:0] PW_WAKE = 2'd3;

  // Short delays, cast to the timer width
  localparam [31:0] SLEEP_CYC = `SFE_SLEEP_ENTRY_CYC;
  localparam [31:0] WAKE_CYC = `SFE_WAKE_CYC;
  localparam [31:0] WAKE_ID_CYC = `SFE_WAKE_ID_CYC;

  // Synchronised pins
  wire s_cs_n; // Chip select, active low
  wire s_sclk; // Serial clock
  wire [3:0] s_io; // Data lines in

  sfe_sync #(.W(6)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .d({spi_cs_n, spi_sclk, io_in}),
    .q({s_cs_n, s_sclk, s_io})
  );

  reg sclk_d_q, cs_d_q; // Edge history of synchronised pins

  // Frame state
  reg [31:0] sh_q; // Received bits
  reg [5:0] cnt_q; // Received bit count, saturating
  reg [7:0] op_q; // Captured opcode
  reg out_ph_q; // Data-out phase of an ID read
  reg [15:0] out_sr_q; // Rotating ID pattern
  reg drive_q; // Output lines enabled
  reg [3:0] dout_q; // Output line values

  // Control state
  reg wel_q; // Write-unlock latch
  reg quad_q; // Four-line command mode
  reg [1:0] pw_q; // Power state
  reg busy_q; // Busy flag to the outside
  reg sleep_out_q; // Deep sleep indicator
  reg e64_go_q; // Block erase start pulse
  reg [2:0] blk_q; // Block being erased
  reg wipe_go_q; // Array erase start pulse

  // Timer controls and status
  wire erase_run, pw_done, erase_load, pw_load;
  wire [31:0] erase_val, pw_val;

  // Edge strobes
  wire sclk_rise = s_sclk & ~sclk_d_q;
  wire sclk_fall = ~s_sclk & sclk_d_q;
  wire cs_rise = s_cs_n & ~cs_d_q;

  // One or four bits per clock
  wire [5:0] step = quad_q ? 6'd4 : 6'd1;
  wire [31:0] sh_nx = quad_q ? {sh_q[27:0], s_io} : {sh_q[30:0], s_io[0]};
  wire [5:0] cnt_nx = (cnt_q > `SFE_CNT_SAT_LIM) ? `SFE_CNT_SAT : cnt_q + step;

  // Busy covers own erases and outside program/status-write cycles
  wire busy = erase_run | ext_busy;
  wire asleep = (pw_q != PW_STBY);
  wire idle = ~busy & ~asleep;
  wire [2:0] blk = sh_q[`SFE_BLK_HI:`SFE_BLK_LO];

  // Frame-length checks at the deselect edge
  wire len_opc = (cnt_q == `SFE_OPC_BITS);
  wire len_addr = (cnt_q == `SFE_ADDR_FRAME_BITS);

  // Protection: top blocks covered, doubling per level
  reg prot_hit;
  always @* begin
    prot_hit = 1'b0;
    case (protect_level_bits)
      4'd0: prot_hit = 1'b0; // Nothing covered
      4'd1: prot_hit = (blk == 3'd7);
      4'd2: prot_hit = (blk >= 3'd6);
      4'd3: prot_hit = (blk >= 3'd4);
      default: prot_hit = 1'b1; // Whole array covered
    endcase
  end

  // Decoded end-of-frame actions
  wire e64_go = cs_rise & (op_q == `SFE_OP_ERASE_64K) & len_addr
              & wel_q & idle & ~prot_hit;
  wire wipe_op = (op_q == `SFE_OP_WIPE_A) | (op_q == `SFE_OP_WIPE_B);
  wire wipe_go = cs_rise & wipe_op & len_opc
               & wel_q & idle & (protect_level_bits == 4'd0);
  wire wel_set = cs_rise & (op_q == `SFE_OP_WRITE_UNLOCK) & len_opc & idle;
  wire sleep_go = cs_rise & (op_q == `SFE_OP_SLEEP_ENTRY) & len_opc
                & idle;
  wire wake_go = cs_rise & (op_q == `SFE_OP_WAKE_ID) & ~busy
               & ((pw_q == PW_ENTER) | (pw_q == PW_SLEEP))
               & (cnt_q >= `SFE_OPC_BITS);
  wire quad_on = cs_rise & (op_q == `SFE_OP_QUAD_ENTRY) & len_opc & idle;
  wire quad_off = cs_rise & (op_q == `SFE_OP_QUAD_EXIT) & len_opc & idle & quad_q;

  // ID stream allowed only when no cycle runs
  wire id_ok = ~busy & ((op_q == `SFE_OP_WAKE_ID)
             | ((op_q == `SFE_OP_MFR_DEV_ID) & ~asleep));
  // Address bit zero picks which byte leads
  wire [15:0] id_pat = (op_q == `SFE_OP_WAKE_ID) ? {DEV_ID, DEV_ID} :
                       (sh_nx[0] ? {DEV_ID, MFR_ID} : {MFR_ID, DEV_ID});

  // Edge history; read only from second sync stage
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_q <= 1'b1; // Same as the sync reset level: no false edge
      cs_d_q <= 1'b1;
    end else if (ce) begin
      sclk_d_q <= s_sclk;
      cs_d_q <= s_cs_n;
    end
  end

  // Serial frame engine
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= 32'h0000_0000;
      cnt_q <= 6'h00;
      op_q <= 8'h00;
      out_ph_q <= 1'b0;
      out_sr_q <= 16'h0000;
      drive_q <= 1'b0;
      dout_q <= 4'h0;
    end else if (ce) begin
      if (s_cs_n) begin
        // Deselected: frame over, lines released
        cnt_q <= 6'h00;
        out_ph_q <= 1'b0;
        drive_q <= 1'b0;
      end else begin
        // Bits taken on rising edges until data-out starts
        if (sclk_rise && !out_ph_q) begin
          sh_q <= sh_nx;
          cnt_q <= cnt_nx;
          if (cnt_nx == `SFE_OPC_BITS) begin
            op_q <= sh_nx[7:0];
          end
          // Opcode plus three address or dummy bytes done
          if (cnt_nx == `SFE_ADDR_FRAME_BITS && id_ok) begin
            out_ph_q <= 1'b1;
            out_sr_q <= id_pat;
          end
        end
        // Output changes on falling edges, MSB first, repeating
        if (sclk_fall && out_ph_q) begin
          drive_q <= 1'b1;
          if (quad_q) begin
            dout_q <= out_sr_q[15:12];
            out_sr_q <= {out_sr_q[11:0], out_sr_q[15:12]};
          end else begin
            dout_q <= {2'b00, out_sr_q[15], 1'b0};
            out_sr_q <= {out_sr_q[14:0], out_sr_q[15]};
          end
        end
      end
    end
  end

  // Write-unlock latch and four-line mode
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wel_q <= 1'b0;
      quad_q <= 1'b0;
    end else if (ce) begin
      if (e64_go || wipe_go) begin
        // Cleared at start, well before the cycle ends
        wel_q <= 1'b0;
      end else if (wel_set) begin
        wel_q <= 1'b1;
      end
      if (quad_on) begin
        quad_q <= 1'b1;
      end else if (quad_off) begin
        quad_q <= 1'b0;
      end
    end
  end

  // Erase requests to the array
  assign erase_load = e64_go | wipe_go;
  assign erase_val = e64_go ? ERASE64K_CYC : WIPE_CYC;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      e64_go_q <= 1'b0;
      wipe_go_q <= 1'b0;
      blk_q <= 3'd0;
      busy_q <= 1'b0;
    end else if (ce) begin
      e64_go_q <= e64_go;
      wipe_go_q <= wipe_go;
      if (e64_go) begin
        blk_q <= blk;
      end
      // Also high on the start cycle so no gap shows
      busy_q <= busy | erase_load;
    end
  end

  sfe_timer #(.CW(32)) u_erase_tmr (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .load(erase_load),
    .load_val(erase_val),
    .run(erase_run),
    .done()
  );

  // Power delays: bare wake and wake with ID each use their own figure
  assign pw_load = sleep_go | wake_go;
  assign pw_val = sleep_go ? SLEEP_CYC :
                  (len_opc ? WAKE_CYC : WAKE_ID_CYC);

  sfe_timer #(.CW(32)) u_pw_tmr (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .load(pw_load),
    .load_val(pw_val),
    .run(),
    .done(pw_done)
  );

  // Power state; reset is power-up, so always standby
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pw_q <= PW_STBY;
      sleep_out_q <= 1'b0;
    end else if (ce) begin
      case (pw_q)
        PW_STBY: begin
          if (sleep_go) begin
            pw_q <= PW_ENTER;
          end
        end
        PW_ENTER: begin
          if (wake_go) begin
            pw_q <= PW_WAKE;
          end else if (pw_done) begin
            pw_q <= PW_SLEEP;
          end
        end
        PW_SLEEP: begin
          // Only the wake opcode is acted upon here
          if (wake_go) begin
            pw_q <= PW_WAKE;
          end
        end
        PW_WAKE: begin
          // Host keeps select high meanwhile; frames are ignored, except that a wake/ID read still streams the ID
          if (pw_done) begin
            pw_q <= PW_STBY;
          end
        end
        default: begin
          pw_q <= PW_STBY;
        end
      endcase
      sleep_out_q <= (pw_q == PW_SLEEP);
    end
  end

  // Pin drive: one line in single mode, all four in four-line mode
  assign io_out = dout_q;
  assign io_oe_n = drive_q ? (quad_q ? 4'h0 : 4'hd) : 4'hf;

  assign busy_flag = busy_q;
  assign write_unlock_latch = wel_q;
  assign deep_sleep = sleep_out_q;
  assign four_line_cmd_mode = quad_q;
  assign erase_64k_go = e64_go_q;
  assign erase_block = blk_q;
  assign array_wipe_go = wipe_go_q;

endmodule

`default_nettype wire

// *** sfe_host.sv ***
// SPI host model for the flash sequencer, mode 0, clock idle low.
// Assumes mclk is the bench clock; pins move on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module sfe_host (
  input wire mclk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic [3:0] io_in,
  input wire [3:0] io_out,
  input wire [3:0] io_oe_n
);
  localparam int HALF = 8; // Mclk per sclk phase, well above the sync delay
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    io_in = 4'h0;
  end
  // Wait whole mclk cycles
  task automatic hw(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One frame: shift nb bits w at a time, then read nr bits
  task automatic frame(input logic [63:0] d, input int nb, input int nr,
                       input int w, output logic [15:0] rd, output logic oe);
    rd = 16'h0;
    oe = 1'b0;
    hw(1);
    spi_cs_n = 1'b0;
    for (int i = 0; i < nb / w; i++) begin
      io_in = (w == 4) ? d[63:60] : {3'b000, d[63]};
      d = d << w;
      hw(HALF);
      spi_sclk = 1'b1;
      hw(HALF);
      spi_sclk = 1'b0;
    end
    for (int i = 0; i < nr / w; i++) begin
      hw(HALF);
      io_in = ~io_in; // Idle line toggles, never a stale value
      spi_sclk = 1'b1;
      // Released lines read high through the pull-ups
      rd = (w == 4) ? {rd[11:0], io_out | io_oe_n} : {rd[14:0], io_out[1] | io_oe_n[1]};
      oe = oe | ~io_oe_n[1];
      hw(HALF);
      spi_sclk = 1'b0;
    end
    hw(HALF);
    spi_cs_n = 1'b1;
    io_in = ~io_in;
    hw(HALF); // Select held high past the sync delay
  endtask
endmodule
`default_nettype wire

// *** sfe_regs.vh ***
// Constants for the serial flash erase, sleep and ID sequencer.
// Assumes a 40 MHz system clock; included by the sequencer files.
`ifndef SFE_REGS_VH
`define SFE_REGS_VH

// Instruction opcodes
`define SFE_OP_ERASE_64K 8'hd8
`define SFE_OP_WIPE_A 8'hc7
`define SFE_OP_WIPE_B 8'h60
`define SFE_OP_SLEEP_ENTRY 8'hb9
`define SFE_OP_WAKE_ID 8'hab
`define SFE_OP_MFR_DEV_ID 8'h90
`define SFE_OP_WRITE_UNLOCK 8'h06
`define SFE_OP_QUAD_ENTRY 8'h38
`define SFE_OP_QUAD_EXIT 8'hff

// Frame lengths in received bits
`define SFE_OPC_BITS 6'd8
`define SFE_ADDR_FRAME_BITS 6'd32
`define SFE_CNT_SAT 6'd63
`define SFE_CNT_SAT_LIM 6'd59

// Block number field inside the 24-bit address
`define SFE_BLK_HI 18
`define SFE_BLK_LO 16

// System clock period
`define SFE_CLK_NS 25

// Self-timed and power delays, figures in their own unit
`define SFE_T_ERASE64K_US 100000
`define SFE_T_WIPE_US 1000000
`define SFE_T_SLEEP_ENTRY_NS 3000
`define SFE_T_WAKE_NS 3000
`define SFE_T_WAKE_ID_NS 3000

// Cycle counts; all round down
`define SFE_ERASE64K_CYC (`SFE_T_ERASE64K_US * 1000 / `SFE_CLK_NS)
`define SFE_WIPE_CYC (`SFE_T_WIPE_US * 1000 / `SFE_CLK_NS)
`define SFE_SLEEP_ENTRY_CYC (`SFE_T_SLEEP_ENTRY_NS / `SFE_CLK_NS)
`define SFE_WAKE_CYC (`SFE_T_WAKE_NS / `SFE_CLK_NS)
`define SFE_WAKE_ID_CYC (`SFE_T_WAKE_ID_NS / `SFE_CLK_NS)

`endif

// *** sfe_sync.v ***
// Two-flop synchroniser bank for the SPI pins.
// Assumes inputs are asynchronous to mclk; only q may be read downstream.
`timescale 1ns/1ps
`default_nettype none

module sfe_sync #(
  parameter W = 6
) (
  input wire mclk,
  input wire arst_n,
  input wire ce,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q; // First stage, read only by the second
  reg [W-1:0] sync_q; // Second stage, safe to use

  // Plain two-stage capture
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

`default_nettype wire

// *** sfe_timer.v ***
// Down-counting delay timer for self-timed cycles and power delays.
// Assumes load is a one-cycle pulse from logic on mclk.
`timescale 1ns/1ps
`default_nettype none

module sfe_timer #(
  parameter CW = 32
) (
  input wire mclk,
  input wire arst_n,
  input wire ce,
  input wire load,
  input wire [CW-1:0] load_val,
  output wire run,
  output wire done
);

  reg [CW-1:0] cnt_q; // Cycles left

  // Load wins over counting
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {CW{1'b0}};
    end else if (ce) begin
      if (load) begin
        cnt_q <= load_val;
      end else if (cnt_q != {CW{1'b0}}) begin
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign run = (cnt_q != {CW{1'b0}});
  // Last counting cycle; only meaningful while ce is high
  assign done = (cnt_q == {{(CW-1){1'b0}}, 1'b1}) & ce & ~load;

endmodule

`default_nettype wire

// *** testbench.sv ***
// Bench for sfe_flash_seq: host model, reference model and checks.
// Assumes sfe_host.sv and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sfe_regs.vh"
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, a); end end
module testbench;
  localparam [7:0] DEV = 8'h3c; // Arbitrary value
  localparam [7:0] MFR = 8'h71; // Arbitrary value
  logic mclk, arst_n, ext_busy; // Bench driven inputs
  logic [3:0] prot; // Protection level
  logic [31:0] rs = 32'haf78; // Xorshift state
  logic [31:0] a; // Random address
  logic [15:0] rd; // Read-back bits
  logic oe; // Output seen driven
  wire cs_n, sclk, busy, latch, sleep, quad, go, wipe;
  wire [3:0] io_in, io_out, io_oe_n;
  wire [2:0] blk;
  int n_errors = 0;
  int comparisons = 0;
  int exp_q[$]; // Model: blocks due to start
  int n_wipe = 0; // Array erases seen
  int m_latch = 0; // Model latch
  int e;
  sfe_flash_seq #(.ERASE64K_CYC(32'd20), .WIPE_CYC(32'd30), .DEV_ID(DEV), .MFR_ID(MFR)) uut (
    .mclk(mclk), .arst_n(arst_n), .ce(1'b1), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .protect_level_bits(prot),
    .ext_busy(ext_busy), .busy_flag(busy), .write_unlock_latch(latch), .deep_sleep(sleep),
    .four_line_cmd_mode(quad), .erase_64k_go(go), .erase_block(blk), .array_wipe_go(wipe));
  sfe_host host (.mclk(mclk), .spi_cs_n(cs_n), .spi_sclk(sclk), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Starts checked against the model queue, away from the launching edge
  always @(negedge mclk) begin
    if (go === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8;
      `CHK("erase block", e, {29'h0, blk})
    end
    if (wipe === 1'b1) n_wipe++;
  end
  // Watchdog, sized at five times the expected run
  initial begin
    repeat (80000) @(posedge mclk);
    n_errors++;
    stop_test();
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic int hit(input int l, input int b);
    return l == 0 ? 0 : l == 1 ? b == 7 : l == 2 ? b >= 6 : l == 3 ? b >= 4 : 1;
  endfunction
  task automatic op(input [7:0] c, input int w);
    host.frame({c, 56'h0}, 8, 0, w, rd, oe);
  endtask
  task automatic unlock(input int w);
    op(`SFE_OP_WRITE_UNLOCK, w);
    m_latch = 1;
    `CHK("latch set", m_latch, latch)
  endtask
  // Block erase of n bits; the model decides whether it starts
  task automatic erase(input [23:0] ad, input int n, input int w);
    int s;
    s = m_latch && n == 32 && !hit(prot, ad[18:16]);
    if (s) exp_q.push_back(ad[18:16]);
    if (s) m_latch = 0;
    host.frame({`SFE_OP_ERASE_64K, ad, 32'h0}, n, 0, w, rd, oe);
    `CHK("left", 0, exp_q.size())
    `CHK("latch", m_latch, latch)
    `CHK("busy", s, busy)
    repeat (30) @(negedge mclk);
    `CHK("busy end", 1'b0, busy)
  endtask
  task automatic wipe_t(input [7:0] c, input int n);
    int b;
    b = n_wipe + (m_latch && n == 8 && prot == 0);
    if (b != n_wipe) m_latch = 0;
    host.frame({c, 56'h0}, n, 0, 1, rd, oe);
    `CHK("wipes", b, n_wipe)
    `CHK("latch", m_latch, latch)
    repeat (40) @(negedge mclk);
  endtask
  task automatic id(input [7:0] c, input [23:0] ad, input int w, input [15:0] x);
    host.frame({c, ad, 32'h0}, 32, 16, w, rd, oe);
    `CHK("id", x, rd)
    `CHK("oe on", 1'b1, oe)
    `CHK("oe off", 4'hf, io_oe_n)
  endtask
  initial begin
    arst_n = 1'b0;
    ext_busy = 1'b0;
    prot = 4'h0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    repeat (5) @(negedge mclk);
    `CHK("sleep", 1'b0, sleep)
    `CHK("oe", 4'hf, io_oe_n)
    erase(24'h05abcd, 32, 1);
    unlock(1);
    erase(24'h05abcd, 32, 1);
    unlock(1);
    erase(24'h030000, 31, 1);
    for (int l = 0; l < 5; l++) begin
      prot = l[3:0];
      a = rnd();
      unlock(1);
      erase({5'h0, 3'd7, a[15:0]}, 32, 1);
      unlock(1);
      erase(a[23:0], 32, 1);
    end
    $display("block erase tests done");
    prot = 4'h1;
    wipe_t(`SFE_OP_WIPE_A, 8);
    prot = 4'h0;
    wipe_t(`SFE_OP_WIPE_A, 9);
    wipe_t(`SFE_OP_WIPE_A, 8);
    unlock(1);
    wipe_t(`SFE_OP_WIPE_B, 8);
    $display("array erase tests done");
    id(`SFE_OP_WAKE_ID, 24'h0, 1, {DEV, DEV});
    id(`SFE_OP_MFR_DEV_ID, 24'h0, 1, {MFR, DEV});
    id(`SFE_OP_MFR_DEV_ID, 24'h1, 1, {DEV, MFR});
    $display("id tests done");
    op(`SFE_OP_SLEEP_ENTRY, 1);
    repeat (130) @(negedge mclk);
    `CHK("asleep", 1'b1, sleep)
    op(`SFE_OP_WRITE_UNLOCK, 1);
    `CHK("latch asleep", 1'b0, latch)
    op(`SFE_OP_WAKE_ID, 1);
    repeat (130) @(negedge mclk);
    `CHK("woken", 1'b0, sleep)
    unlock(1);
    op(`SFE_OP_SLEEP_ENTRY, 1);
    repeat (130) @(negedge mclk);
    id(`SFE_OP_WAKE_ID, 24'h0, 1, {DEV, DEV});
    repeat (130) @(negedge mclk);
    `CHK("woken id", 1'b0, sleep)
    ext_busy = 1'b1;
    op(`SFE_OP_SLEEP_ENTRY, 1);
    repeat (130) @(negedge mclk);
    `CHK("sleep busy", 1'b0, sleep)
    host.frame({`SFE_OP_WAKE_ID, 56'h0}, 32, 16, 1, rd, oe);
    `CHK("oe busy", 1'b0, oe)
    `CHK("rd busy", 16'hffff, rd)
    ext_busy = 1'b0;
    $display("sleep tests done");
    op(`SFE_OP_QUAD_ENTRY, 1);
    `CHK("quad", 1'b1, quad)
    unlock(4);
    erase(24'h02ffff, 32, 4);
    id(`SFE_OP_WAKE_ID, 24'h0, 4, {DEV, DEV});
    op(`SFE_OP_QUAD_EXIT, 4);
    `CHK("quad off", 1'b0, quad)
    $display("four line tests done");
    stop_test();
  end
endmodule
`default_nettype wire
